// file: dcfg_conv_model.sv
/*
 Behavioural converter-interface partner for the command decoder.
 Assumes requests arrive on a valid/ready handshake in the decoder's clock domain.
*/
`timescale 1ns/1ps
module dcfg_conv_model
   import dcfg_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire dcfg_conv_req_t req,
   input wire logic valid,
   input wire logic [7:0] delay,
   output logic ready_q,
   output dcfg_conv_req_t got_q,
   output logic [7:0] count_q
);
   logic [7:0] wait_q;

   // Ready holds until a transfer completes, so a decoder that drops valid early is served once it raises valid again
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ready_q <= 1'b0;
         wait_q <= 8'h00;
         count_q <= 8'h00;
         got_q <= '0;
      end else if (valid && ready_q) begin
         ready_q <= 1'b0;
         wait_q <= 8'h00;
         count_q <= count_q + 8'h01;
         got_q <= req;
      end else if (valid) begin
         wait_q <= wait_q + 8'h01;
         ready_q <= (wait_q >= delay);
      end
   end
endmodule // dcfg_conv_model

// file: dcfg_decoder.sv
/*
 Configuration command decoder: AXI4-Lite slave taking command identifier and
 payload, decoding ADC/DAC/sawtooth/threshold/acquisition commands, handing
 converter requests to an external converter interface with valid/ready.
 Assumes a single clock and a converter interface that raises ready when free.
*/
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
// Behaviour
// - ADC write: bit 31 broadcasts to all chips, bit 27 selects upper-channel chip.
// - ADC register address 0x2A in bits 25-18 means gain for channels 8-11.
// - Command 0x0105 restores all DAC defaults; payload ignored.
// - Command 0x0106: data bits 9-0, address bits 16-13, code bits 20-17.
// - DAC chip in bits 26-23, type in 28-27: energy, timing, reserved, all.
// - DAC write bit 31 applies to every chip of the selected type.
// - Channel n maps to chip n/4, address n mod 4; address 0xF hits all four.
// - Command 0x0107 sends bits 13-6 pulses; chip 3-0, type 5-4, bit 31 broadcast.
// - Command 0x0108 stores 12-bit threshold, mode 01 enables, 00 disables.
// - Threshold is offset binary: all ones max, zeros min, top bit midpoint.
// - Command 0x0109 replies with last stored threshold and mode.
// - Acquisition modes raw, processed, idle with run, stop, reset actions.
`timescale 1ns/1ps
module dcfg_decoder
   import dcfg_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RESETN,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output dcfg_conv_req_t CONV_REQ,
   output logic CONV_VALID,
   input wire logic CONV_READY,
   output logic [11:0] FW_THRESHOLD,
   output logic FW_TRIG_EN,
   output logic [1:0] ACQ_MODE,
   output logic [3:0] ACQ_ACTION,
   output logic [31:0] ACQ_SETTINGS
);
   logic aw_hold_q, w_hold_q, awready_q, wready_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q, arready_q, rvalid_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic [15:0] command_identifier_q;
   logic [31:0] payload_q;
   logic [31:0] reply_q;
   logic busy_q, done_q, async_q;
   dcfg_state_t state_q;
   dcfg_conv_req_t req_q;
   logic conv_valid_q, trig_en_q;
   logic [11:0] thr_q;
   logic [1:0] tmode_q;
   logic [1:0] mode_q;
   logic [3:0] action_q;
   logic [31:0] settings_q;
   logic wr_fire, go;
   logic [31:0] wmask;
   logic [15:0] base_id;
   dcfg_conv_req_t dec_d;
   logic dec_conv;

   // Write channel: address and data latched independently, either order
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         aw_hold_q <= 1'b0;
         awready_q <= 1'b1;
         aw_addr_q <= 8'h00;
      end else if (wr_fire) begin
         aw_hold_q <= 1'b0;
         awready_q <= 1'b1;
      end else if (S_AXI_AWVALID && !aw_hold_q) begin
         aw_hold_q <= 1'b1;
         awready_q <= 1'b0;
         aw_addr_q <= S_AXI_AWADDR;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         w_hold_q <= 1'b0;
         wready_q <= 1'b1;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
      end else if (wr_fire) begin
         w_hold_q <= 1'b0;
         wready_q <= 1'b1;
      end else if (S_AXI_WVALID && !w_hold_q) begin
         w_hold_q <= 1'b1;
         wready_q <= 1'b0;
         w_data_q <= S_AXI_WDATA;
         w_strb_q <= S_AXI_WSTRB;
      end
   end

   assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
   assign S_AXI_AWREADY = awready_q;
   assign S_AXI_WREADY = wready_q;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_strb
         assign wmask[gi*8 +: 8] = {8{w_strb_q[gi]}};
      end
   endgenerate

   // A command write while busy is refused so the pending request survives
   assign go = wr_fire && aw_addr_q == DCFG_REG_CMD && !busy_q;

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         bvalid_q <= 1'b0;
         bresp_q <= DCFG_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         unique case (aw_addr_q)
            DCFG_REG_CMD: bresp_q <= busy_q ? DCFG_RESP_SLVERR : DCFG_RESP_OKAY;
            DCFG_REG_PAYLOAD, DCFG_REG_MODE, DCFG_REG_SETTINGS, DCFG_REG_DONE:
               bresp_q <= DCFG_RESP_OKAY;
            default: bresp_q <= DCFG_RESP_SLVERR;
         endcase
      end else if (S_AXI_BREADY) begin
         bvalid_q <= 1'b0;
      end
   end
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         payload_q <= 32'h00000000;
         command_identifier_q <= 16'h0000;
      end else if (wr_fire && aw_addr_q == DCFG_REG_PAYLOAD) begin
         payload_q <= (payload_q & ~wmask) | (w_data_q & wmask);
      end else if (go) begin
         command_identifier_q <= w_data_q[15:0];
      end
   end

   // Command decode from latest identifier write and stored payload
   assign base_id = w_data_q[15:0] & ~DCFG_ASYNC_BIT;
   always_comb begin
      dec_d = '0;
      dec_conv = 1'b0;
      unique case (base_id)
         DCFG_CMD_ADC_WR: begin
            dec_conv = 1'b1;
            dec_d.adc = 1'b1;
            dec_d.bcast = payload_q[31];
            dec_d.addr = {3'b000, payload_q[27]};
            dec_d.reg_addr = payload_q[25:18];
            dec_d.gain_hi = payload_q[25:18] == DCFG_ADC_GAIN_HI && payload_q[27];
            dec_d.data = payload_q[15:0];
         end
         DCFG_CMD_DAC_RST: begin
            dec_conv = 1'b1;
            dec_d.dac_reset = 1'b1;
            dec_d.bcast = 1'b1;
            dec_d.dtype = DCFG_TYPE_ALL;
         end
         DCFG_CMD_DAC_WR: begin
            dec_conv = 1'b1;
            dec_d.data = {6'h00, payload_q[9:0]};
            dec_d.addr = payload_q[16:13];
            dec_d.code = payload_q[20:17];
            dec_d.chip = payload_q[26:23];
            dec_d.dtype = payload_q[28:27];
            dec_d.bcast = payload_q[31];
         end
         DCFG_CMD_SAW: begin
            dec_conv = 1'b1;
            dec_d.saw = 1'b1;
            dec_d.chip = payload_q[3:0];
            dec_d.dtype = payload_q[5:4];
            dec_d.data = {8'h00, payload_q[13:6]};
            dec_d.bcast = payload_q[31];
         end
         default: begin
            dec_conv = 1'b0;
         end
      endcase
   end

   // Command sequencer; async identifiers release the host at once
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_q <= DCFG_IDLE;
         req_q <= '0;
         conv_valid_q <= 1'b0;
         busy_q <= 1'b0;
         async_q <= 1'b0;
      end else begin
         unique case (state_q)
            DCFG_IDLE: begin
               if (go && dec_conv) begin
                  state_q <= DCFG_ISSUE;
                  req_q <= dec_d;
                  conv_valid_q <= 1'b1;
                  busy_q <= 1'b1;
                  async_q <= w_data_q[15];
               end
            end
            DCFG_ISSUE: begin
               if (CONV_READY) begin
                  conv_valid_q <= 1'b0;
                  state_q <= DCFG_WAIT;
               end
            end
            DCFG_WAIT: begin
               state_q <= DCFG_IDLE;
               busy_q <= 1'b0;
            end
         endcase
      end
   end
   assign CONV_REQ = req_q;
   assign CONV_VALID = conv_valid_q;

   // Reply-ready flag: hardware set wins over software clear
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         done_q <= 1'b0;
      end else if ((state_q == DCFG_ISSUE && CONV_READY) ||
                   (go && (!dec_conv || w_data_q[15]))) begin
         done_q <= 1'b1;
      end else if (go || (wr_fire && aw_addr_q == DCFG_REG_DONE && w_data_q[0])) begin
         done_q <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         thr_q <= DCFG_THR_RESET;
         tmode_q <= DCFG_TMODE_OFF;
         trig_en_q <= 1'b0;
      end else if (go && base_id == DCFG_CMD_THR_SET) begin
         thr_q <= payload_q[11:0];
         if (payload_q[17:16] == DCFG_TMODE_ON || payload_q[17:16] == DCFG_TMODE_OFF) begin
            tmode_q <= payload_q[17:16];
            trig_en_q <= payload_q[17:16] == DCFG_TMODE_ON;
         end
      end
   end
   assign FW_THRESHOLD = thr_q;
   assign FW_TRIG_EN = trig_en_q;

   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         reply_q <= 32'h00000000;
      end else if (go) begin
         if (base_id == DCFG_CMD_THR_GET || base_id == DCFG_CMD_THR_SET) begin
            reply_q <= {14'h0000, tmode_q, 4'h0, thr_q};
            if (base_id == DCFG_CMD_THR_SET) begin
               reply_q <= {14'h0000, payload_q[17:16], 4'h0, payload_q[11:0]};
            end
         end else begin
            reply_q <= 32'h00000000;
         end
      end
   end

   // Acquisition mode, action and settings word
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         mode_q <= DCFG_ACQ_IDLE;
         action_q <= DCFG_ACT_RESET;
         settings_q <= 32'h00000000;
      end else if (wr_fire && aw_addr_q == DCFG_REG_MODE) begin
         if (w_data_q[1:0] != 2'h3) begin
            mode_q <= w_data_q[1:0];
         end
         if (w_data_q[7:4] <= DCFG_ACT_RUN) begin
            action_q <= w_data_q[7:4];
         end
         if (w_data_q[7:4] == DCFG_ACT_RESET) begin
            settings_q <= 32'h00000000;
         end
      end else if (wr_fire && aw_addr_q == DCFG_REG_SETTINGS) begin
         settings_q <= (settings_q & ~wmask) | (w_data_q & wmask);
      end
   end
   assign ACQ_MODE = mode_q;
   assign ACQ_ACTION = action_q;
   assign ACQ_SETTINGS = settings_q;

   // Read channel: one read in flight
   assign S_AXI_ARREADY = arready_q;
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= DCFG_RESP_OKAY;
      end else if (S_AXI_ARVALID && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rresp_q <= DCFG_RESP_OKAY;
         unique case (S_AXI_ARADDR)
            DCFG_REG_CMD: rdata_q <= {16'h0000, command_identifier_q};
            DCFG_REG_PAYLOAD: rdata_q <= payload_q;
            DCFG_REG_STATUS: rdata_q <= {28'h0000000, async_q, conv_valid_q, done_q, busy_q};
            DCFG_REG_REPLY: rdata_q <= reply_q;
            DCFG_REG_THRESH: rdata_q <= {14'h0000, tmode_q, 4'h0, thr_q};
            DCFG_REG_MODE: rdata_q <= {24'h000000, action_q, 2'b00, mode_q};
            DCFG_REG_SETTINGS: rdata_q <= settings_q;
            DCFG_REG_DONE: rdata_q <= {31'h00000000, done_q};
            default: begin
               rdata_q <= 32'h00000000;
               rresp_q <= DCFG_RESP_SLVERR;
            end
         endcase
      end else if (rvalid_q && S_AXI_RREADY) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;

   a_req_stable: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      CONV_VALID && !CONV_READY |=> CONV_VALID && $stable(CONV_REQ))
      else $error("converter request changed before acceptance");
   a_done_after_hand: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      state_q == DCFG_ISSUE && CONV_READY |=> done_q && !CONV_VALID)
      else $error("reply not ready after converter handover");
   a_dac_reset_all: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      go && base_id == DCFG_CMD_DAC_RST && state_q == DCFG_IDLE |=>
      CONV_REQ.dac_reset && CONV_REQ.dtype == DCFG_TYPE_ALL)
      else $error("DAC reset not issued to all");
   a_dac_fields: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      go && base_id == DCFG_CMD_DAC_WR && state_q == DCFG_IDLE |=>
      CONV_REQ.data[9:0] == $past(payload_q[9:0]) && CONV_REQ.chip == $past(payload_q[26:23]))
      else $error("DAC write fields wrong");
   a_saw_count: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      go && base_id == DCFG_CMD_SAW && state_q == DCFG_IDLE |=>
      CONV_REQ.saw && CONV_REQ.data[7:0] == $past(payload_q[13:6]))
      else $error("sawtooth count wrong");
   a_adc_bcast: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      go && base_id == DCFG_CMD_ADC_WR && state_q == DCFG_IDLE |=>
      CONV_REQ.bcast == $past(payload_q[31]) && CONV_REQ.addr[0] == $past(payload_q[27]))
      else $error("ADC broadcast or chip wrong");
   a_thr_store: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      go && base_id == DCFG_CMD_THR_SET && payload_q[17:16] == DCFG_TMODE_ON |=>
      FW_TRIG_EN && FW_THRESHOLD == $past(payload_q[11:0]))
      else $error("threshold not stored");
   a_thr_reply: assert property (@(posedge SYS_CLK) disable iff (!RESETN)
      go && base_id == DCFG_CMD_THR_GET |=> reply_q[11:0] == FW_THRESHOLD && reply_q[31:18] == 14'h0000)
      else $error("threshold reply wrong");
endmodule // dcfg_decoder

// file: dcfg_pkg.sv
/*
 Shared constants and types for the configuration command decoder.
 Assumes a single 50 MHz clock domain and an AXI4-Lite register master.
*/
package dcfg_pkg;
   localparam logic [7:0] DCFG_REG_CMD = 8'h00;
   localparam logic [7:0] DCFG_REG_PAYLOAD = 8'h04;
   localparam logic [7:0] DCFG_REG_STATUS = 8'h08;
   localparam logic [7:0] DCFG_REG_REPLY = 8'h0C;
   localparam logic [7:0] DCFG_REG_THRESH = 8'h10;
   localparam logic [7:0] DCFG_REG_MODE = 8'h14;
   localparam logic [7:0] DCFG_REG_SETTINGS = 8'h18;
   localparam logic [7:0] DCFG_REG_DONE = 8'h1C;
   localparam logic [15:0] DCFG_CMD_ADC_WR = 16'h0104;
   localparam logic [15:0] DCFG_CMD_DAC_RST = 16'h0105;
   localparam logic [15:0] DCFG_CMD_DAC_WR = 16'h0106;
   localparam logic [15:0] DCFG_CMD_SAW = 16'h0107;
   localparam logic [15:0] DCFG_CMD_THR_SET = 16'h0108;
   localparam logic [15:0] DCFG_CMD_THR_GET = 16'h0109;
   localparam logic [15:0] DCFG_ASYNC_BIT = 16'h8000;
   localparam logic [7:0] DCFG_ADC_GAIN_HI = 8'h2A;
   localparam logic [3:0] DCFG_DAC_ALL_ADDR = 4'hF;
   localparam logic [1:0] DCFG_TYPE_ALL = 2'h3;
   localparam logic [1:0] DCFG_TMODE_ON = 2'h1;
   localparam logic [1:0] DCFG_TMODE_OFF = 2'h0;
   localparam logic [11:0] DCFG_THR_RESET = 12'h800;
   localparam logic [1:0] DCFG_ACQ_IDLE = 2'h0;
   localparam logic [1:0] DCFG_ACQ_RAW = 2'h1;
   localparam logic [1:0] DCFG_ACQ_PROC = 2'h2;
   localparam logic [3:0] DCFG_ACT_RESET = 4'h0;
   localparam logic [3:0] DCFG_ACT_STOP = 4'h1;
   localparam logic [3:0] DCFG_ACT_RUN = 4'h2;
   localparam logic [1:0] DCFG_RESP_OKAY = 2'b00;
   localparam logic [1:0] DCFG_RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {DCFG_IDLE = 2'b00, DCFG_ISSUE = 2'b01,
      DCFG_WAIT = 2'b11} dcfg_state_t;

   // Converter request handed to the converter interface
   typedef struct packed {
      logic adc;           // 1: ADC write, 0: DAC side
      logic dac_reset;
      logic saw;
      logic bcast;
      logic [1:0] dtype;
      logic [3:0] chip;
      logic [3:0] addr;    // DAC address or ADC chip in bit 0
      logic [3:0] code;
      logic [15:0] data;   // ADC data, DAC data or pulse count
      logic [7:0] reg_addr;
      logic gain_hi;
   } dcfg_conv_req_t;
endpackage : dcfg_pkg

// file: detector_config_command_decoder_tb_top.sv
/*
 Self-checking bench for the command decoder: AXI4-Lite master tasks and
 command sequences. Assumes the converter partner model beside the decoder.
*/
`timescale 1ns/1ps
module detector_config_command_decoder_tb_top;
   import dcfg_pkg::*;
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, delay = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, conv_valid, conv_ready, fw_trig_en;
   logic [1:0] bresp, rresp, acq_mode, resp_l;
   logic [31:0] rdata, acq_settings, data_l;
   logic [11:0] fw_threshold;
   logic [3:0] acq_action;
   logic [7:0] count;
   dcfg_conv_req_t conv_req, got;
   int n_fail = 0;
   int num_checks = 0;
   int m;
   int a;
   logic [1:0] modes [3] = '{DCFG_ACQ_IDLE, DCFG_ACQ_RAW, DCFG_ACQ_PROC};
   logic [31:0] dac_p [4] = '{32'h0086_0120, 32'h8986_00CD, 32'h69E6_3FFF, 32'h9907_E200};

   always #10 sys_clk = ~sys_clk;

   dcfg_decoder i_dut (.SYS_CLK(sys_clk), .RESETN(resetn), .S_AXI_AWADDR(awaddr),
      .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready), .CONV_REQ(conv_req), .CONV_VALID(conv_valid),
      .CONV_READY(conv_ready), .FW_THRESHOLD(fw_threshold), .FW_TRIG_EN(fw_trig_en),
      .ACQ_MODE(acq_mode), .ACQ_ACTION(acq_action), .ACQ_SETTINGS(acq_settings));

   dcfg_conv_model i_conv (.clk(sys_clk), .rst_n(resetn), .req(conv_req), .valid(conv_valid),
      .delay(delay), .ready_q(conv_ready), .got_q(got), .count_q(count));

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic hang();
      n_fail++;
      $display("mismatch at %0t: wait ran out", $time);
      summarize();
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      int i;
      @(posedge sys_clk);
      awaddr <= ad;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge sys_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (i == 100) hang();
      resp_l = bresp;
      bready <= 1'b0;
      @(negedge sys_clk);
   endtask

   task automatic rd(input logic [7:0] ad);
      int i;
      @(posedge sys_clk);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 100; i++) begin
         @(posedge sys_clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (i == 100) hang();
      resp_l = rresp;
      data_l = rdata;
      rready <= 1'b0;
      @(negedge sys_clk);
   endtask

   task automatic issue(input logic [15:0] id, input logic [31:0] p);
      wr(DCFG_REG_DONE, 32'h0000_0001);
      wr(DCFG_REG_PAYLOAD, p);
      wr(DCFG_REG_CMD, {16'h0000, id});
   endtask

   // Polls busy so the next command is never refused by accident
   task automatic settle();
      int k;
      for (k = 0; k < 50; k++) begin
         rd(DCFG_REG_STATUS);
         if (data_l[0] === 1'b0) break;
      end
      if (k == 50) hang();
   endtask

   task automatic run(input logic [15:0] id, input logic [31:0] p);
      issue(id, p);
      settle();
   endtask

   task automatic chk_dac(input logic [31:0] p);
      `CHK(got.adc, 1'b0)
      `CHK(got.data, {6'h00, p[9:0]})
      `CHK(got.addr, p[16:13])
      `CHK(got.code, p[20:17])
      `CHK(got.chip, p[26:23])
      `CHK(got.dtype, p[28:27])
      `CHK(got.bcast, p[31])
   endtask

   task automatic chk_adc(input logic [31:0] p, input logic gain_exp);
      `CHK(got.adc, 1'b1)
      `CHK(got.bcast, p[31])
      `CHK(got.addr[0], p[27])
      `CHK(got.reg_addr, p[25:18])
      `CHK(got.gain_hi, gain_exp)
      `CHK(got.data, p[15:0])
   endtask

   initial begin
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      `CHK(fw_threshold, DCFG_THR_RESET)
      `CHK(fw_trig_en, 1'b0)
      rd(8'h40);
      `CHK(resp_l, DCFG_RESP_SLVERR)
      `CHK(data_l, 32'h0000_0000)
      run(DCFG_CMD_ADC_WR, 32'h88A8_8888);
      chk_adc(32'h88A8_8888, 1'b1);
      // Reserved and unused bits set must not move any field
      run(DCFG_CMD_ADC_WR, 32'h74AF_6666);
      chk_adc(32'h74AF_6666, 1'b0);
      for (m = 0; m < 4; m++) begin
         run(DCFG_CMD_DAC_WR, dac_p[m]);
         chk_dac(dac_p[m]);
      end
      run(DCFG_CMD_DAC_RST, 32'hDEAD_FEED);
      `CHK(got.dac_reset, 1'b1)
      `CHK(got.saw, 1'b0)
      `CHK(count, 8'h07)
      // Stalled converter: blocking command must still be pending
      delay <= 8'h14;
      issue(DCFG_CMD_DAC_WR, dac_p[0]);
      rd(DCFG_REG_STATUS);
      `CHK(data_l[2:0], 3'b101)
      wr(DCFG_REG_CMD, {16'h0000, DCFG_CMD_DAC_RST});
      `CHK(resp_l, DCFG_RESP_SLVERR)
      settle();
      rd(DCFG_REG_STATUS);
      `CHK(data_l[1], 1'b1)
      `CHK(count, 8'h08)
      issue(DCFG_CMD_SAW | DCFG_ASYNC_BIT, 32'h8000_1902);
      rd(DCFG_REG_STATUS);
      `CHK(data_l[3], 1'b1)
      `CHK(data_l[1], 1'b1)
      settle();
      `CHK(got.saw, 1'b1)
      `CHK(got.data, 16'd100)
      `CHK({got.bcast, got.dtype, got.chip}, 7'h42)
      run(DCFG_CMD_THR_SET, 32'h0001_0800);
      `CHK({fw_trig_en, fw_threshold}, 13'h1800)
      rd(DCFG_REG_REPLY);
      `CHK(data_l, 32'h0001_0800)
      run(DCFG_CMD_THR_SET, 32'hFFFC_FFFF);
      `CHK({fw_trig_en, fw_threshold}, 13'h0FFF)
      run(DCFG_CMD_THR_SET, 32'h0001_0000);
      `CHK({fw_trig_en, fw_threshold}, 13'h1000)
      run(DCFG_CMD_THR_GET, 32'hDEAD_FEED);
      rd(DCFG_REG_REPLY);
      `CHK(data_l, 32'h0001_0000)
      // Mode code 10 is not a legal mode: threshold moves, enable stays
      run(DCFG_CMD_THR_SET, 32'h0002_0ABC);
      `CHK({fw_trig_en, fw_threshold}, 13'h1ABC)
      for (m = 0; m < 3; m++) begin
         for (a = 1; a < 3; a++) begin
            wr(DCFG_REG_MODE, {24'h00_0000, a[3:0], 2'b00, modes[m]});
            `CHK({acq_action, acq_mode}, {a[3:0], modes[m]})
         end
      end
      wr(DCFG_REG_SETTINGS, 32'h0200_0101);
      `CHK(acq_settings, 32'h0200_0101)
      wr(DCFG_REG_MODE, {24'h00_0000, DCFG_ACT_RESET, 2'b00, DCFG_ACQ_RAW});
      `CHK(acq_settings, 32'h0000_0000)
      `CHK(acq_action, DCFG_ACT_RESET)
      `CHK(acq_mode, DCFG_ACQ_RAW)
      // Undefined mode and action codes leave both fields alone
      wr(DCFG_REG_MODE, 32'h0000_00F3);
      `CHK({acq_action, acq_mode}, {DCFG_ACT_RESET, DCFG_ACQ_RAW})
      summarize();
   end
endmodule // detector_config_command_decoder_tb_top
